/* include/ssmp_pkg.sv */
package ssmp_pkg;
  // clock and link timing
  localparam int CLK_NS = 10;
  localparam int SCK_HALF_NS = 160;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int ENTRY_WAIT_NS = 20000;
  localparam int ENTRY_WAIT_CYC = (ENTRY_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLASH_PAGE_WAIT_NS = 4500000;
  localparam int FLASH_PAGE_WAIT_CYC = (FLASH_PAGE_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int EEPROM_BYTE_WAIT_NS = 9000000;
  localparam int EEPROM_BYTE_WAIT_CYC = (EEPROM_BYTE_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 20;
  localparam logic [4:0] HALF_LAST = 5'(SCK_HALF_CYC - 1);
  localparam logic [4:0] LAST_BIT = 5'h1f;
  localparam logic [2:0] ENABLE_TRIES = 3'h4;
  // instruction bytes
  localparam logic [7:0] OPC_EN1 = 8'hac;
  localparam logic [7:0] OPC_EN2 = 8'h53;
  localparam logic [7:0] OPC_LOAD = 8'h40;
  localparam logic [7:0] OPC_PAGE_WR = 8'h4c;
  localparam logic [7:0] OPC_EE_WR = 8'hc0;
  localparam logic [7:0] OPC_FL_RD = 8'h20;
  localparam logic [7:0] OPC_EE_RD = 8'ha0;
  localparam logic [7:0] OPC_HSEL = 8'h08;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] PAD = 8'h00;
  localparam int ECHO_LSB = 8;
  localparam int HSEL_BIT = 27;

  typedef enum logic [2:0] {
    OP_ENABLE, OP_LOAD, OP_PAGE_WR, OP_EE_WR, OP_FL_RD, OP_EE_RD, OP_END
  } ssmp_op_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RST_WAIT, ST_RST_PULSE, ST_SHIFT, ST_DECIDE, ST_WAIT
  } ssmp_st_t;
  typedef enum logic [1:0] {PH_ENABLE, PH_LOW, PH_CMD, PH_POLL} ssmp_ph_t;
endpackage

/* design/ssmp_host.sv */
module ssmp_host
  import ssmp_pkg::*;
#(
  parameter int FLASH_WAIT_CYC = FLASH_PAGE_WAIT_CYC,
  parameter int EE_WAIT_CYC = EEPROM_BYTE_WAIT_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // programming link
  output logic prog_sck,
  output logic prog_serial_in,
  input wire logic prog_serial_out,
  output logic dev_rst_n,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire ssmp_op_t cmd_op,
  input wire logic [15:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_high,
  input wire logic cmd_poll,
  // response
  output logic rsp_valid,
  output logic rsp_ok,
  output logic [7:0] rsp_data
);

  typedef struct packed {
    ssmp_st_t st;
    ssmp_ph_t ph;
    ssmp_op_t op;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic high;
    logic poll;
    logic enabled;
    logic [2:0] tries;
    logic [TMR_W-1:0] timer;
    logic [4:0] half;
    logic [4:0] nbit;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [1:0] miso_sync;
    logic sck;
    logic mosi;
    logic dev_rst_n;
    logic cmd_ready;
    logic rsp_valid;
    logic rsp_ok;
    logic [7:0] rsp_data;
  } ssmp_host_t;

  ssmp_host_t s;
  ssmp_host_t n;

  // builds the four-byte frame of an instruction
  function automatic logic [31:0] frame(ssmp_op_t op, logic [15:0] a, logic [15:0] d,
                                        logic hi);
    logic [7:0] hsel;
    hsel = hi ? OPC_HSEL : PAD;
    unique case (op)
      OP_LOAD: frame = {OPC_LOAD | hsel, PAD, 1'b0, a[6:0], hi ? d[15:8] : d[7:0]};
      OP_PAGE_WR: frame = {OPC_PAGE_WR, a[15:8], a[7], 7'h00, PAD};
      OP_EE_WR: frame = {OPC_EE_WR, 4'h0, a[11:8], a[7:0], d[7:0]};
      OP_FL_RD: frame = {OPC_FL_RD | hsel, a[15:8], a[7:0], PAD};
      OP_EE_RD: frame = {OPC_EE_RD, 4'h0, a[11:8], a[7:0], PAD};
      default: frame = {OPC_EN1, OPC_EN2, PAD, PAD};
    endcase
  endfunction

  // starts shifting a frame, msb first
  function automatic ssmp_host_t go(ssmp_host_t v, logic [31:0] f);
    ssmp_host_t r;
    r = v;
    r.tx = f;
    r.mosi = f[31];
    r.st = ST_SHIFT;
    r.half = '0;
    r.nbit = '0;
    r.sck = 1'b0;
    return r;
  endfunction

  function automatic ssmp_host_t finish(ssmp_host_t v, logic ok);
    ssmp_host_t r;
    r = v;
    r.st = ST_IDLE;
    r.cmd_ready = 1'b1;
    r.rsp_valid = 1'b1;
    r.rsp_ok = ok;
    return r;
  endfunction

  always_comb begin
    n = s;
    n.miso_sync = {s.miso_sync[0], prog_serial_out};
    n.rsp_valid = 1'b0;
    if (s.timer != '0) begin
      n.timer = s.timer - 1'b1;
    end
    unique case (s.st)
      ST_IDLE: begin
        if (cmd_valid) begin
          n.op = cmd_op;
          n.addr = cmd_addr;
          n.wdata = cmd_wdata;
          n.high = cmd_high;
          n.poll = cmd_poll;
          n.cmd_ready = 1'b0;
          if (cmd_op == OP_END) begin
            n.dev_rst_n = 1'b1;
            n.enabled = 1'b0;
            n = finish(n, 1'b1);
          end else if (cmd_op == OP_ENABLE) begin
            n.dev_rst_n = 1'b0;
            n.tries = ENABLE_TRIES;
            n.timer = TMR_W'(ENTRY_WAIT_CYC);
            n.st = ST_RST_WAIT;
          end else if (!s.enabled) begin
            n = finish(n, 1'b0);
          end else begin
            n = go(n, frame(cmd_op, cmd_addr, cmd_wdata, cmd_high && cmd_op != OP_LOAD));
            n.ph = (cmd_op == OP_LOAD) ? PH_LOW : PH_CMD;
          end
        end
      end
      ST_RST_WAIT: begin
        if (s.timer == '0) begin
          n = go(n, frame(OP_ENABLE, s.addr, s.wdata, 1'b0));
          n.ph = PH_ENABLE;
        end
      end
      ST_RST_PULSE: begin
        if (s.timer == '0) begin
          n.dev_rst_n = 1'b0;
          n.timer = TMR_W'(ENTRY_WAIT_CYC);
          n.st = ST_RST_WAIT;
        end
      end
      ST_SHIFT: begin
        n.half = s.half + 1'b1;
        if (s.half == HALF_LAST) begin
          n.half = '0;
          n.sck = !s.sck;
          if (s.sck) begin
            n.rx = {s.rx[30:0], s.miso_sync[1]};
            n.tx = {s.tx[30:0], 1'b0};
            n.mosi = s.tx[30];
            n.nbit = s.nbit + 1'b1;
            if (s.nbit == LAST_BIT) begin
              n.mosi = 1'b0;
              n.st = ST_DECIDE;
            end
          end
        end
      end
      ST_DECIDE: begin
        n.rsp_data = s.rx[7:0];
        unique case (s.ph)
          PH_ENABLE: begin
            // echo checked after all four bytes
            if (s.rx[ECHO_LSB+7:ECHO_LSB] == OPC_EN2) begin
              n.enabled = 1'b1;
              n = finish(n, 1'b1);
            end else if (s.tries > 3'h1) begin
              n.tries = s.tries - 1'b1;
              n.dev_rst_n = 1'b1;
              n.timer = TMR_W'(ENTRY_WAIT_CYC);
              n.st = ST_RST_PULSE;
            end else begin
              n = finish(n, 1'b0);
            end
          end
          PH_LOW: begin
            n = go(n, frame(OP_LOAD, s.addr, s.wdata, 1'b1));
            n.ph = PH_CMD;
          end
          default: begin
            if (s.op == OP_PAGE_WR || s.op == OP_EE_WR) begin
              if (s.ph == PH_CMD) begin
                n.timer = (s.op == OP_PAGE_WR) ? TMR_W'(FLASH_WAIT_CYC) : TMR_W'(EE_WAIT_CYC);
              end
              if (s.ph == PH_POLL && s.rx[7:0] == s.wdata[7:0]) begin
                n = finish(n, 1'b1);
              end else if (s.poll && s.wdata[7:0] != ALL_ONES
                           && (s.ph == PH_CMD || s.timer != '0)) begin
                n = go(n, frame(s.op == OP_PAGE_WR ? OP_FL_RD : OP_EE_RD,
                                s.addr, s.wdata, 1'b0));
                n.ph = PH_POLL;
              end else begin
                n.st = ST_WAIT;
              end
            end else begin
              n = finish(n, 1'b1);
            end
          end
        endcase
      end
      ST_WAIT: begin
        if (s.timer == '0) begin
          n = finish(n, 1'b1);
        end
      end
      default: n.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.dev_rst_n <= 1'b1;
      s.cmd_ready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign prog_sck = s.sck;
  assign prog_serial_in = s.mosi;
  assign dev_rst_n = s.dev_rst_n;
  assign cmd_ready = s.cmd_ready;
  assign rsp_valid = s.rsp_valid;
  assign rsp_ok = s.rsp_ok;
  assign rsp_data = s.rsp_data;

  property p_frame_len;
    @(posedge ref_clk) disable iff (!nrst)
      (s.st == ST_SHIFT) ##1 (s.st == ST_DECIDE)
      |-> $past(s.nbit) == LAST_BIT && s.nbit == 5'h00 && !s.sck;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not 32 bits");

  property p_full_enable;
    @(posedge ref_clk) disable iff (!nrst)
      $rose(s.st == ST_SHIFT) && s.ph == PH_ENABLE |-> s.tx == {OPC_EN1, OPC_EN2, PAD, PAD};
  endproperty
  a_full_enable: assert property (p_full_enable) else $error("bad enable frame");

  property p_resync;
    @(posedge ref_clk) disable iff (!nrst)
      s.st == ST_DECIDE && s.ph == PH_ENABLE && s.rx[15:8] != OPC_EN2 && s.tries > 3'h1
      |=> s.st == ST_RST_PULSE && dev_rst_n ##1 dev_rst_n;
  endproperty
  a_resync: assert property (p_resync) else $error("no reset pulse on bad echo");

  property p_sck_in_reset;
    @(posedge ref_clk) disable iff (!nrst)
      $rose(prog_sck) |-> !dev_rst_n && $past(!dev_rst_n, 2);
  endproperty
  a_sck_in_reset: assert property (p_sck_in_reset) else $error("clock while reset high");

  property p_page_opc;
    @(posedge ref_clk) disable iff (!nrst)
      $rose(s.st == ST_SHIFT) && s.op == OP_PAGE_WR && s.ph == PH_CMD
      |-> s.tx[31:24] == OPC_PAGE_WR && s.tx[23:15] == s.addr[15:7] && s.tx[14:0] == 15'h0000;
  endproperty
  a_page_opc: assert property (p_page_opc) else $error("bad page write frame");

  property p_low_first;
    @(posedge ref_clk) disable iff (!nrst)
      $rose(s.st == ST_SHIFT) && s.op == OP_LOAD |-> s.tx[HSEL_BIT] == (s.ph == PH_CMD);
  endproperty
  a_low_first: assert property (p_low_first) else $error("high byte before low");

  property p_ee_wait;
    @(posedge ref_clk) disable iff (!nrst)
      s.st == ST_DECIDE && s.ph == PH_CMD && s.op == OP_EE_WR && !s.poll
      |=> s.st == ST_WAIT && s.timer == TMR_W'(EE_WAIT_CYC);
  endproperty
  a_ee_wait: assert property (p_ee_wait) else $error("eeprom wait not loaded");

  property p_quiet_wait;
    @(posedge ref_clk) disable iff (!nrst)
      s.st == ST_WAIT |-> !prog_sck && !cmd_ready && !prog_serial_in;
  endproperty
  a_quiet_wait: assert property (p_quiet_wait) else $error("link active during write");

  property p_end;
    @(posedge ref_clk) disable iff (!nrst)
      cmd_valid && cmd_ready && cmd_op == OP_END |=> dev_rst_n && rsp_valid && rsp_ok;
  endproperty
  a_end: assert property (p_end) else $error("reset not released at end");

  property p_no_poll_ones;
    @(posedge ref_clk) disable iff (!nrst)
      s.st == ST_DECIDE && s.ph == PH_CMD && s.op == OP_PAGE_WR && s.wdata[7:0] == ALL_ONES
      |=> s.st == ST_WAIT && s.timer == TMR_W'(FLASH_WAIT_CYC);
  endproperty
  a_no_poll_ones: assert property (p_no_poll_ones) else $error("polled an all-ones value");

endmodule

/* tb/ssmp_dev_model.sv */
module ssmp_dev_model
  import ssmp_pkg::*;
#(
  parameter int FL_NS = 12000,
  parameter int EE_NS = 15000
) (
  // link
  input wire logic prog_sck,
  input wire logic prog_serial_in,
  input wire logic dev_rst_n,
  output logic prog_serial_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] fl[int], ee[int], pbuf[int];
  logic [31:0] f = '0;
  logic [7:0] ob = '0;
  logic en = 1'b0;
  int bad_n = 0, tries = 0, viol = 0, nb = 0, pg = -1, ea = -1;
  realtime fl_t = -1.0e9, ee_t = -1.0e9;
  function automatic logic [7:0] rd();
    int ka = int'(f[11:0]);
    int kf = int'({f[15:0], f[19]});
    if (f[23:16] == OPC_EE_RD)
      return ($realtime - ee_t < EE_NS && ka == ea) || !ee.exists(ka) ? ALL_ONES : ee[ka];
    return ($realtime - fl_t < FL_NS && kf / 256 == pg) || !fl.exists(kf) ? ALL_ONES : fl[kf];
  endfunction
  task automatic decode();
    if (f[31:16] == {OPC_EN1, OPC_EN2}) begin
      tries++;
      if (bad_n > 0)
        bad_n--;
      else
        en = 1'b1;
    end else if (en) begin
      case (f[31:24])
        OPC_LOAD, OPC_LOAD | OPC_HSEL: begin
          if (f[27] && !pbuf.exists(int'({f[14:8], 1'b0})))
            viol++;
          pbuf[int'({f[14:8], f[27]})] = f[7:0];
        end
        OPC_PAGE_WR: begin
          pg = int'(f[23:15]);
          foreach (pbuf[k])
            fl[pg * 256 + k] = pbuf[k];
          pbuf.delete();
          fl_t = $realtime;
        end
        OPC_EE_WR: begin
          ea = int'(f[19:8]);
          ee[ea] = f[7:0];
          ee_t = $realtime;
        end
        default: ;
      endcase
    end
  endtask
  always @(posedge prog_sck) begin
    if (!dev_rst_n) begin
      f = {f[30:0], prog_serial_in};
      nb++;
      if (nb % 32 == 8 && ($realtime - fl_t < FL_NS || $realtime - ee_t < EE_NS) &&
          (f[7:0] & ~OPC_HSEL) != OPC_FL_RD && f[7:0] != OPC_EE_RD)
        viol++;
      if (nb % 32 == 0)
        decode();
    end
  end
  always @(negedge prog_sck) begin
    if (!dev_rst_n) begin
      if (nb % 32 == 16)
        ob = bad_n > 0 ? ~f[7:0] : f[7:0];
      else if (nb % 32 == 24)
        ob = en ? rd() : PAD;
      else if (nb % 8 == 0)
        ob = PAD;
      else
        ob = ob << 1;
    end
  end
  always @(dev_rst_n) begin
    nb = 0;
    en = 1'b0;
    pbuf.delete();
  end
  assign prog_serial_out = dev_rst_n ? ~ob[7] : ob[7];
endmodule

/* tb/spi_serial_memory_programming_tb.sv */
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %0t got %0h exp %0h", $time, (g), (e)); end end
module spi_serial_memory_programming_tb;
  import ssmp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FW = 3000, EW = 4000, FR = 1024, LIM = 100000;
  logic ref_clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, cmd_high = 1'b0, cmd_poll = 1'b0;
  ssmp_op_t cmd_op = OP_END;
  logic [15:0] cmd_addr = '0, cmd_wdata = '0;
  logic prog_sck, prog_serial_in, prog_serial_out, dev_rst_n, cmd_ready, rsp_valid, rsp_ok;
  logic r_ok;
  logic [7:0] rsp_data, r_dat;
  logic [7:0] ref_fl[int];
  int miscompares = 0, check_count = 0, cyc = 0, el = 0;
  ssmp_host #(.FLASH_WAIT_CYC(FW), .EE_WAIT_CYC(EW)) i_dut (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .prog_sck(prog_sck),
    .prog_serial_in(prog_serial_in),
    .prog_serial_out(prog_serial_out),
    .dev_rst_n(dev_rst_n),
    .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready),
    .cmd_op(cmd_op),
    .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata),
    .cmd_high(cmd_high),
    .cmd_poll(cmd_poll),
    .rsp_valid(rsp_valid),
    .rsp_ok(rsp_ok),
    .rsp_data(rsp_data)
  );
  ssmp_dev_model i_dev (
    .prog_sck(prog_sck),
    .prog_serial_in(prog_serial_in),
    .dev_rst_n(dev_rst_n),
    .prog_serial_out(prog_serial_out)
  );
  initial forever #5 ref_clk = ~ref_clk;
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == LIM) begin
      miscompares++;
      print_verdict();
    end
  end
  function automatic logic [7:0] exp_fl(input logic [15:0] wa, input logic h);
    return ref_fl.exists(int'({wa, h})) ? ref_fl[int'({wa, h})] : ALL_ONES;
  endfunction
  task automatic run(input ssmp_op_t op, input logic [15:0] a, input logic [15:0] d,
                     input logic h, input logic p);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_high <= h;
    cmd_poll <= p;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    el = 1;
    while (rsp_valid !== 1'b1) begin
      @(posedge ref_clk);
      el++;
      if (el == 2 && rsp_valid !== 1'b1) `CHK(cmd_ready, 1'b0)
    end
    `CHK(cmd_ready, 1'b1)
    r_ok = rsp_ok;
    r_dat = rsp_data;
  endtask
  initial begin
    int pg, a;
    logic [15:0] w;
    logic [15:0] wa[3];
    logic [7:0] v;
    logic [11:0] ea;
    void'($urandom(39));
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    run(OP_EE_WR, 16'h0001, 16'h0055, 1'b0, 1'b0);
    `CHK(r_ok, 1'b0)
    i_dev.bad_n = 4;
    run(OP_ENABLE, '0, '0, 1'b0, 1'b0);
    `CHK(r_ok, 1'b0)
    `CHK(i_dev.tries, 4)
    i_dev.bad_n = 1;
    run(OP_ENABLE, '0, '0, 1'b0, 1'b0);
    `CHK(r_ok, 1'b1)
    `CHK(i_dev.tries, 6)
    // random words into one page
    pg = $urandom_range(511, 0);
    for (int k = 0; k < 3; k++) begin
      a = k * 37 + $urandom_range(36, 0);
      w = 16'($urandom);
      if (w[7:0] == ALL_ONES)
        w[7:0] = 8'h5a;
      wa[k] = 16'({pg[8:0], a[6:0]});
      ref_fl[int'({wa[k], 1'b0})] = w[7:0];
      ref_fl[int'({wa[k], 1'b1})] = w[15:8];
      run(OP_LOAD, wa[k], w, 1'b0, 1'b0);
      `CHK(r_ok, 1'b1)
    end
    run(OP_PAGE_WR, wa[0], 16'(exp_fl(wa[0], 1'b0)), 1'b0, 1'b1);
    `CHK(r_ok, 1'b1)
    `CHK(el < FW + FR, 1'b1)
    for (int k = 0; k < 6; k++) begin
      run(OP_FL_RD, wa[k / 2], '0, k[0], 1'b0);
      `CHK(r_dat, exp_fl(wa[k / 2], k[0]))
    end
    // all-ones low byte forces fixed wait
    wa[0] = 16'({pg[8:0] ^ 9'h001, 7'h00});
    ref_fl[int'({wa[0], 1'b1})] = 8'h12;
    run(OP_LOAD, wa[0], 16'h12ff, 1'b0, 1'b0);
    for (int p = 0; p < 2; p++) begin
      run(OP_PAGE_WR, wa[0], 16'h00ff, 1'b0, p[0]);
      `CHK(el >= FW + FR, 1'b1)
    end
    run(OP_FL_RD, wa[0], '0, 1'b1, 1'b0);
    `CHK(r_dat, exp_fl(wa[0], 1'b1))
    // eeprom byte writes on one address
    ea = 12'($urandom);
    v = 8'($urandom_range(254, 0));
    run(OP_EE_WR, 16'(ea), 16'(v), 1'b0, 1'b1);
    `CHK(r_ok, 1'b1)
    `CHK(el < EW + FR, 1'b1)
    run(OP_EE_WR, 16'(ea), 16'h00ff, 1'b0, 1'b1);
    `CHK(el >= EW + FR, 1'b1)
    v = {v[3:0], v[7:4]};
    run(OP_EE_WR, 16'(ea), 16'(v), 1'b0, 1'b0);
    `CHK(el >= EW + FR, 1'b1)
    run(OP_EE_RD, 16'(ea), '0, 1'b0, 1'b0);
    `CHK(r_dat, v)
    run(OP_END, '0, '0, 1'b0, 1'b0);
    repeat (2) @(posedge ref_clk);
    `CHK(dev_rst_n, 1'b1)
    run(OP_FL_RD, wa[0], '0, 1'b0, 1'b0);
    `CHK(r_ok, 1'b0)
    `CHK(i_dev.viol, 0)
    print_verdict();
  end
endmodule
